// file: verilog/chan_switch_seq.sv
// Notes on behaviour
// RL1 - Driver itself lacks break-first protection
// RL2 - Code change while gated may overlap
// RL3 - Gate low turns every output off
// RL4 - Drop gate before any code change
// RL5 - Wait 10 us before changing code
// RL6 - Place new code while gate low
// RL7 - Wait 40 us more before gate high
// RL8 - Raise gate; only addressed output on
// RL9 - Wait 10 us after gate high
// RL10 - Power-up: gate low, code first
// RL11 - Five-bit code selects one of 32
// RL12 - Code is unsigned binary, bit0 lsb
`timescale 1ns/1ps
module chan_switch_seq #(
    parameter int DIS_CYC = chan_seq_pkg::DISABLE_PROP_CYC,   // Gate-off settle
    parameter int ADR_CYC = chan_seq_pkg::ADDR_SETTLE_CYC,    // Address settle
    parameter int ENA_CYC = chan_seq_pkg::ENABLE_SETTLE_CYC   // Turn-on settle
) (
    input  wire logic                           sys_clk,        // 200 MHz clock
    input  wire logic                           rst_n,          // Async reset, low
    input  wire logic                           req_valid,      // Switch request
    input  wire logic [chan_seq_pkg::SEL_W-1:0] req_code,       // Output to select
    input  wire logic                           req_gate,       // 1 = turn on, 0 = off
    input  wire logic                           hold_off,       // Async force-off pin
    output logic                                req_ready,      // Ready for request
    output logic                                busy,           // Sequence running
    output logic [chan_seq_pkg::SEL_W-1:0]      select_code,    // To address pins
    output logic                                gate            // To gate pin
);

    // ****************************************
    // State
    // ****************************************
    chan_seq_pkg::seq_state_e       state_reg;
    chan_seq_pkg::seq_state_e       state_next;
    chan_seq_pkg::pins_s            pins_reg;
    chan_seq_pkg::pins_s            pins_next;
    chan_seq_pkg::pins_s            pend_reg;
    chan_seq_pkg::pins_s            pend_next;
    logic [chan_seq_pkg::CNT_W-1:0] cnt_reg;
    logic [chan_seq_pkg::CNT_W-1:0] cnt_next;
    logic                           ready_reg;
    logic                           ready_next;
    logic                           busy_reg;
    logic                           busy_next;
    logic                           hold_lvl;
    logic                           take;
    logic                           force_off;
    logic                           cnt_zero;

    // Pin from outside the clock domain
    sync_stage #(
        .W (1)
    ) u_hold_sync (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .async_in  (hold_off),
        .level_out (hold_lvl)
    );

    // ****************************************
    // Counter helpers
    // ****************************************
    // Waits load cyc-1 and stop at zero, so each lasts exactly cyc cycles
    function automatic logic [chan_seq_pkg::CNT_W-1:0] load_cnt(input int cyc);
        load_cnt = chan_seq_pkg::CNT_W'(cyc - 1);
    endfunction

    function automatic logic [chan_seq_pkg::CNT_W-1:0] dec_cnt(
        input logic [chan_seq_pkg::CNT_W-1:0] cnt
    );
        dec_cnt = cnt - 1'b1;
    endfunction

    // ****************************************
    // Request decisions
    // ****************************************
    // A ready already shown is honoured even if hold arrives with it;
    // the hold then only keeps the gate low at the raise step
    always_comb
    begin
        cnt_zero  = (cnt_reg == '0);
        take      = (state_reg == chan_seq_pkg::ST_IDLE) && req_valid && ready_reg;
        force_off = (state_reg == chan_seq_pkg::ST_IDLE) && !take && hold_lvl && pins_reg.gate;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        pend_next  = pend_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            chan_seq_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    pend_next.gate        = req_gate;
                    pend_next.select_code = req_code;                         // RL12
                    cnt_next              = load_cnt(DIS_CYC);
                    state_next            = chan_seq_pkg::ST_GATE_OFF;
                end
                else if (force_off)
                begin
                    // Forced off still honours the full break time
                    pend_next.gate        = 1'b0;                             // RL10
                    pend_next.select_code = pins_reg.select_code;
                    cnt_next              = load_cnt(DIS_CYC);
                    state_next            = chan_seq_pkg::ST_GATE_OFF;
                end
            end
            chan_seq_pkg::ST_GATE_OFF:
            begin
                if (cnt_zero)
                begin
                    cnt_next   = load_cnt(ADR_CYC);
                    state_next = chan_seq_pkg::ST_ADDR_SET;
                end
                else
                    cnt_next = dec_cnt(cnt_reg);                              // RL5
            end
            chan_seq_pkg::ST_ADDR_SET:
            begin
                if (cnt_zero)
                begin
                    cnt_next   = load_cnt(ENA_CYC);
                    state_next = chan_seq_pkg::ST_GATE_ON;
                end
                else
                    cnt_next = dec_cnt(cnt_reg);                              // RL7
            end
            chan_seq_pkg::ST_GATE_ON:
            begin
                if (cnt_zero)
                    state_next = chan_seq_pkg::ST_IDLE;
                else
                    cnt_next = dec_cnt(cnt_reg);                              // RL9
            end
            default:
            begin
                state_next = chan_seq_pkg::ST_IDLE;
                cnt_next   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= chan_seq_pkg::ST_IDLE;
            pend_reg  <= '{gate: 1'b0, select_code: chan_seq_pkg::SEL_RESET};
            cnt_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            pend_reg  <= pend_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    always_comb
    begin
        pins_next = pins_reg;
        case (state_reg)
            chan_seq_pkg::ST_IDLE:
            begin
                if (take)
                    pins_next.gate = 1'b0;                                    // RL4
                else if (force_off)
                    pins_next.gate = 1'b0;                                    // RL3
            end
            chan_seq_pkg::ST_GATE_OFF:
            begin
                // Gate still low here, never changed while high
                if (cnt_zero)
                    pins_next.select_code = pend_reg.select_code;             // RL6
            end
            chan_seq_pkg::ST_ADDR_SET:
            begin
                // Overlap avoided in the driver only by this ordering
                if (cnt_zero)
                    pins_next.gate = pend_reg.gate & ~hold_lvl;               // RL8
            end
            chan_seq_pkg::ST_GATE_ON:
                pins_next = pins_reg;
            default:
                pins_next.gate = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pins_reg <= '{gate: 1'b0, select_code: chan_seq_pkg::SEL_RESET};  // RL10
        else
            pins_reg <= pins_next;
    end

    // ****************************************
    // Handshake flags
    // ****************************************
    // Ready only while idle and not held, so a held block shows no ready
    always_comb
    begin
        ready_next = 1'b0;
        busy_next  = 1'b1;
        if (state_next == chan_seq_pkg::ST_IDLE)
        begin
            ready_next = ~hold_lvl;
            busy_next  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end
        else
        begin
            ready_reg <= ready_next;
            busy_reg  <= busy_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign select_code = pins_reg.select_code;                                // RL11
    assign gate        = pins_reg.gate;
    assign req_ready   = ready_reg;
    assign busy        = busy_reg;

endmodule // chan_switch_seq

// file: pkg/chan_seq_pkg.sv
package chan_seq_pkg;

    // ****************************************
    // Pin widths and clock rate
    // ****************************************
    localparam int SEL_W       = 5;
    localparam int CLK_MHZ     = 200;
    localparam int SYNC_STAGES = 3;

    // ****************************************
    // Switch timing, microseconds as printed
    // ****************************************
    localparam int DISABLE_PROP_US  = 10;
    localparam int ADDR_SETTLE_US   = 40;
    localparam int ENABLE_SETTLE_US = 10;

    // Least times: exact multiples here, so rounding up changes nothing
    localparam int DISABLE_PROP_CYC  = DISABLE_PROP_US * CLK_MHZ;
    localparam int ADDR_SETTLE_CYC   = ADDR_SETTLE_US * CLK_MHZ;
    localparam int ENABLE_SETTLE_CYC = ENABLE_SETTLE_US * CLK_MHZ;

    localparam int CNT_W = 16;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic             gate;
        logic [SEL_W-1:0] select_code;
    } pins_s;

    typedef enum {
        ST_IDLE,
        ST_GATE_OFF,
        ST_ADDR_SET,
        ST_GATE_ON
    } seq_state_e;

endpackage

// file: verilog/sync_stage.sv
`timescale 1ns/1ps
module sync_stage #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,    // System clock
    input  wire logic         rst_n,      // Async reset, active low
    input  wire logic [W-1:0] async_in,   // Signal from another domain
    output logic      [W-1:0] level_out   // Accepted level
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // Change only counts once stages two and three agree
    always_comb
    begin
        level_next = level_reg;
        for (int i = 0; i < W; i++)
        begin
            if (s2_reg[i] == s3_reg[i])
                level_next[i] = s2_reg[i];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end
        else
        begin
            s1_reg    <= async_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;

endmodule // sync_stage

// file: verif/chan_seq_chk.sv
`timescale 1ns/1ps
module chan_seq_chk #(
    parameter int DIS_CYC = 4,  // Gate-off settle
    parameter int ADR_CYC = 6,  // Address settle
    parameter int ENA_CYC = 3   // Turn-on settle
) (
    input wire logic       sys_clk,     // Clock
    input wire logic       rst_n,       // Reset, low
    input wire logic       req_valid,   // Request
    input wire logic [4:0] req_code,    // Wanted code
    input wire logic       req_gate,    // Wanted gate
    input wire logic       req_ready,   // Ready
    input wire logic       busy,        // Busy
    input wire logic [4:0] select_code, // Address pins
    input wire logic       gate         // Gate pin
);
    localparam int SEQ_LEN = 1 + DIS_CYC + ADR_CYC + ENA_CYC;
    logic [15:0] off_cnt, adr_cnt, on_cnt;
    logic [4:0]  want_code;
    logic        want_gate;
    // Saturating ages of gate-low, last code change, gate-high
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            off_cnt <= '0;
            adr_cnt <= '0;
            on_cnt <= '0;
            want_code <= chan_seq_pkg::SEL_RESET;
            want_gate <= 1'b0;
        end
        else
        begin
            off_cnt <= gate ? '0 : off_cnt + 16'(off_cnt != '1);
            on_cnt <= !gate ? '0 : on_cnt + 16'(on_cnt != '1);
            adr_cnt <= $changed(select_code) ? 16'h1 : adr_cnt + 16'(adr_cnt != '1);
            if (req_valid && req_ready)
            begin
                want_code <= req_code;
                want_gate <= req_gate;
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_off; !gate && busy && !req_ready; endsequence
    property p_drop; s_take |=> s_off; endproperty
    property p_low; $changed(select_code) |-> !gate && !$past(gate); endproperty
    property p_dis; $changed(select_code) |-> off_cnt >= DIS_CYC; endproperty
    property p_adr; $rose(gate) |-> adr_cnt >= ADR_CYC; endproperty
    property p_ena; (s_take ##0 gate) |-> on_cnt >= ENA_CYC; endproperty
    property p_rise; $rose(gate) |-> want_gate && select_code == want_code; endproperty
    property p_final; $fell(busy) |-> select_code == want_code; endproperty
    property p_rst; $rose(rst_n) |-> !gate && select_code == chan_seq_pkg::SEL_RESET; endproperty
    property p_done; s_take |-> ##[1:SEQ_LEN] $fell(busy); endproperty
    a_drop: assert property (p_drop) else $error("gate kept after take");
    a_low: assert property (p_low) else $error("code moved while gated");
    a_dis: assert property (p_dis) else $error("code moved too early");
    a_adr: assert property (p_adr) else $error("gate raised too early");
    a_ena: assert property (p_ena) else $error("next switch too early");
    a_rise: assert property (p_rise) else $error("wrong gate raise");
    a_final: assert property (p_final) else $error("wrong final code");
    a_rst: assert property (p_rst) else $error("bad state after reset");
    a_done: assert property (p_done) else $error("sequence overran");
endmodule // chan_seq_chk

// file: verif/drv_model.sv
`timescale 1ns/1ps
module drv_model (
    input wire logic        gate,            // Gate pin
    input wire logic [4:0]  select_code,     // Address pins
    output logic     [31:0] driver_output_n, // One line per output
    output int              overlap_cnt      // Code moves while gated
);
    int cnt = 0;
    // No break-first guard: overlap transient not modelled
    assign driver_output_n = gate ? 32'h1 << select_code : 32'h0;
    assign overlap_cnt = cnt;
    always @(select_code)
        if (gate === 1'b1)
            cnt++;
endmodule // drv_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        sys_clk, rst_n, req_valid, req_gate, hold_off, req_ready, busy, gate, busy_q;
    logic [4:0]  req_code, select_code;
    logic [31:0] driver_output_n, exp_out;
    chan_seq_pkg::pins_s exp_q[$], exp_pins;
    int          overlap_cnt, n_errors, n_checks, seed, i;
    chan_switch_seq #(.DIS_CYC(4), .ADR_CYC(6), .ENA_CYC(3)) i_dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .req_valid(req_valid), .req_code(req_code), .req_gate(req_gate),
        .hold_off(hold_off), .req_ready(req_ready), .busy(busy), .select_code(select_code),
        .gate(gate));
    drv_model i_model (.gate(gate), .select_code(select_code),
        .driver_output_n(driver_output_n), .overlap_cnt(overlap_cnt));
    initial
    begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait: ready, or queue drained when q is set
    task wait_for(input bit q);
        int k;
        k = 0;
        while ((q ? exp_q.size() != 0 : req_ready !== 1'b1) && k < 100)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (q ? exp_q.size() != 0 : req_ready !== 1'b1)
        begin
            n_errors++;
            end_sim;
        end
    endtask
    task send(input logic [4:0] c, input logic g);
        wait_for(0);
        req_valid = 1;
        req_code = c;
        req_gate = g;
        exp_q.push_back('{gate: g, select_code: c});
        @(negedge sys_clk);
        req_valid = 0;
    endtask
    always @(negedge sys_clk)
    begin
        if (busy_q === 1'b0 && busy === 1'b1)
            check("outputs off", 32'h0, driver_output_n);
        if (busy_q === 1'b1 && busy === 1'b0)
        begin
            exp_pins = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
            exp_out = exp_pins.gate ? 32'h1 << exp_pins.select_code : 32'h0;
            check("outputs", exp_out, driver_output_n);
            check("select code", 32'(exp_pins.select_code), 32'(select_code));
            check("ready", 32'(!hold_off), 32'(req_ready));
        end
        busy_q <= busy;
    end
    initial
    begin
        seed = 32'hb5d5;
        n_errors = 0;
        n_checks = 0;
        rst_n = 0;
        req_valid = 0;
        req_code = 0;
        req_gate = 0;
        hold_off = 0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1;
        check("reset outputs", 32'h0, driver_output_n);
        @(negedge sys_clk);
        send(5'h1F, 1);
        send(5'h00, 1);
        send(5'h00, 1);
        $display("test boundary codes done");
        for (i = 0; i < 12; i++)
            send(5'($random(seed)), 1'($random(seed)));
        $display("test random switching done");
        send(5'h03, 1);
        @(negedge sys_clk);
        req_valid = 1;
        req_code = 5'h1C;
        @(negedge sys_clk);
        req_valid = 0;
        wait_for(1);
        $display("test refused request done");
        wait_for(0);
        exp_q.push_back('{gate: 1'b0, select_code: 5'h03});
        hold_off = 1;
        wait_for(1);
        hold_off = 0;
        wait_for(0);
        req_valid = 1;
        req_code = 5'h0A;
        req_gate = 1;
        exp_q.push_back('{gate: 1'b0, select_code: 5'h0A});
        @(negedge sys_clk);
        req_valid = 0;
        hold_off = 1;
        wait_for(1);
        hold_off = 0;
        $display("test hold off done");
        check("overlap count", 32'h0, overlap_cnt);
        end_sim;
    end
endmodule // tb_top
bind chan_switch_seq chan_seq_chk #(.DIS_CYC(DIS_CYC), .ADR_CYC(ADR_CYC), .ENA_CYC(ENA_CYC))
    i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_code(req_code),
    .req_gate(req_gate), .req_ready(req_ready), .busy(busy), .select_code(select_code),
    .gate(gate));
